// ---- rtl/cfr_forced_relay.sv ----
`timescale 1ns/100ps
module cfr_forced_relay
#(
  // Cycles per 0.1 s hold tick
  parameter int TICK_LEN = cfr_pkg::TICK_CYCLES
)
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Avalon-MM slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic [1:0]       avs_response,
  // Relay drives
  output logic [cfr_pkg::NUM_RELAYS-1:0] relay_energize
);
  import cfr_pkg::*;

  logic [NUM_RELAYS-1:0]       permit_reg;
  logic [NUM_RELAYS-1:0]       style_reg;
  logic [OVR_W*NUM_RELAYS-1:0] override_reg;
  logic [DUR_W-1:0]            dur_reg [NUM_RELAYS];
  logic [DUR_W-1:0]            timer   [NUM_RELAYS];
  logic [NUM_RELAYS-1:0]       relay_on;
  logic [NUM_RELAYS-1:0]       apply;
  logic                        blocked;
  logic                        reject_reg;
  logic                        ack_reg;
  logic                        tick;
  logic                        wr_go;
  logic                        rd_go;
  logic                        mapped;
  logic [31:0]                 wdata;
  logic [DUR_W-1:0]            dur_next;

  // One-cycle wait state, answered next edge
  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
  assign wr_go = avs_write && !ack_reg;
  assign rd_go = avs_read && !ack_reg;

  always_comb
  begin
    wdata = '0;
    for (int b = 0; b < 4; b++)
      if (avs_byteenable[b])
        wdata[b*8 +: 8] = avs_writedata[b*8 +: 8];
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      ack_reg <= 1'b0;
    else
      ack_reg <= (avs_read || avs_write) && !ack_reg;
  end

  // Any non-disabled override blocks forcing
  always_comb
  begin
    blocked = 1'b0;
    for (int i = 0; i < NUM_RELAYS; i++)
      if (override_reg[i*OVR_W +: OVR_W] != OVR_DISABLED)
        blocked = 1'b1;
  end

  // Clamp duration writes into legal range
  always_comb
  begin
    dur_next = wdata[DUR_W-1:0];
    if (dur_next < DUR_MIN)
      dur_next = DUR_MIN;
    else if (dur_next > DUR_MAX)
      dur_next = DUR_MAX;
  end

  // Only permitted relays see the command
  always_comb
  begin
    for (int i = 0; i < NUM_RELAYS; i++)
      apply[i] = wr_go && avs_address == ADDR_COMMAND && !blocked
                 && permit_reg[i];
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      permit_reg   <= '0;
      style_reg    <= '0;
      override_reg <= '0;
    end
    else if (wr_go)
    begin
      if (avs_address == ADDR_PERMIT)
        permit_reg <= wdata[NUM_RELAYS-1:0];
      if (avs_address == ADDR_STYLE)
        style_reg <= wdata[NUM_RELAYS-1:0];
      if (avs_address == ADDR_OVERRIDE)
        override_reg <= wdata[OVR_W*NUM_RELAYS-1:0];
    end
  end

  always_ff @(posedge clk)
  begin
    for (int i = 0; i < NUM_RELAYS; i++)
    begin
      if (srst)
        dur_reg[i] <= DUR_DEFAULT;
      else if (wr_go && avs_address == ADDR_DUR_BASE + 6'(4 * i))
        dur_reg[i] <= dur_next;
    end
  end

  // Sticky rejected-command flag, cleared by writing one
  always_ff @(posedge clk)
  begin
    if (srst)
      reject_reg <= 1'b0;
    else if (wr_go && avs_address == ADDR_COMMAND && blocked)
      reject_reg <= 1'b1;
    else if (wr_go && avs_address == ADDR_STATUS && wdata[ST_REJECT_BIT])
      reject_reg <= 1'b0;
  end

  cfr_tick #(.CYCLES(TICK_LEN)) u_tick
  (
    .clk  (clk),
    .srst (srst),
    .tick (tick)
  );

  for (genvar g = 0; g < NUM_RELAYS; g++)
  begin : g_chan
    cfr_relay_chan u_chan
    (
      .clk      (clk),
      .srst     (srst),
      .tick     (tick),
      .apply    (apply[g]),
      .cmd_bit  (wdata[g]),
      .style    (cfr_style_e'(style_reg[g])),
      .duration (dur_reg[g]),
      .relay_on (relay_on[g]),
      .timer    (timer[g])
    );
  end

  assign relay_energize = relay_on;

  always_comb
  begin
    mapped = 1'b0;
    if (avs_address == ADDR_COMMAND || avs_address == ADDR_PERMIT
        || avs_address == ADDR_STYLE || avs_address == ADDR_OVERRIDE
        || avs_address == ADDR_STATUS)
      mapped = 1'b1;
    for (int i = 0; i < NUM_RELAYS; i++)
      if (avs_address == ADDR_DUR_BASE + 6'(4 * i)
          || avs_address == ADDR_TMR_BASE + 6'(4 * i))
        mapped = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      avs_readdata <= '0;
      avs_response <= 2'h0;
    end
    else if (rd_go || wr_go)
    begin
      avs_response <= mapped ? 2'h0 : 2'h3;
      avs_readdata <= '0;
      if (rd_go)
      begin
        case (avs_address)
          ADDR_COMMAND:  avs_readdata <= 32'(relay_on);
          ADDR_PERMIT:   avs_readdata <= 32'(permit_reg);
          ADDR_STYLE:    avs_readdata <= 32'(style_reg);
          ADDR_OVERRIDE: avs_readdata <= 32'(override_reg);
          ADDR_STATUS:   avs_readdata <= 32'({reject_reg, blocked, relay_on});
          default:
          begin
            for (int i = 0; i < NUM_RELAYS; i++)
            begin
              if (avs_address == ADDR_DUR_BASE + 6'(4 * i))
                avs_readdata <= 32'(dur_reg[i]);
              if (avs_address == ADDR_TMR_BASE + 6'(4 * i))
                avs_readdata <= 32'(timer[i]);
            end
          end
        endcase
      end
    end
  end
endmodule : cfr_forced_relay

// ---- rtl/cfr_pkg.sv ----
// Function
// - Force command applies only to relays selected in the permit mask.
// - Command carries one bit per relay: trip, alarm, aux one, aux two.
// - Permitted command bit one energizes, zero de-energizes the relay.
// - Each relay has its own latched or pulsed output style.
// - Latched relay forced on stays on until a zero bit arrives.
// - Pulsed relay forced on stays on for its hold duration, down-counted.
// - Hold duration programmable 0.5 s to 5000.0 s in 0.1 s steps.
// - Hold duration defaults to 0.5 s per relay.
// - Energize during running pulse reloads full duration and restarts countdown.
// - Latched forced relay cleared only by command or power cycle.
// - Any test override other than disabled blocks all force commands.
package cfr_pkg;
  localparam int          NUM_RELAYS      = 4;
  localparam int          RELAY_TRIP      = 0;
  localparam int          RELAY_ALARM     = 1;
  localparam int          RELAY_AUX_ONE   = 2;
  localparam int          RELAY_AUX_TWO   = 3;
  localparam int          DUR_W           = 16;
  localparam logic [15:0] DUR_MIN         = 16'h0005;
  localparam logic [15:0] DUR_MAX         = 16'hc350;
  localparam logic [15:0] DUR_DEFAULT     = 16'h0005;
  localparam int          CLK_HZ          = 250_000_000;
  localparam int          TICK_MS         = 100;
  localparam int          TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
  localparam int          TICK_W          = 25;
  // Register byte addresses
  localparam logic [5:0]  ADDR_COMMAND    = 6'h00;
  localparam logic [5:0]  ADDR_PERMIT     = 6'h04;
  localparam logic [5:0]  ADDR_STYLE      = 6'h08;
  localparam logic [5:0]  ADDR_OVERRIDE   = 6'h0c;
  localparam logic [5:0]  ADDR_STATUS     = 6'h10;
  localparam logic [5:0]  ADDR_DUR_BASE   = 6'h20;
  localparam logic [5:0]  ADDR_TMR_BASE   = 6'h30;
  localparam int          OVR_W           = 2;
  localparam logic [1:0]  OVR_DISABLED    = 2'h0;
  localparam int          ST_BLOCKED_BIT  = 4;
  localparam int          ST_REJECT_BIT   = 5;
  typedef enum logic {CFR_LATCHED, CFR_PULSED} cfr_style_e;
endpackage : cfr_pkg

// ---- rtl/cfr_tick.sv ----
`timescale 1ns/100ps
module cfr_tick
  import cfr_pkg::*;
#(
  parameter int CYCLES = TICK_CYCLES
)
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // Output
  output logic      tick
);
  logic [TICK_W-1:0] cnt_reg;

  always_ff @(posedge clk)
  begin
    if (srst || cnt_reg == TICK_W'(CYCLES - 1))
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_reg + TICK_W'(1);
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      tick <= 1'b0;
    else
      tick <= (cnt_reg == TICK_W'(CYCLES - 1));
  end
endmodule : cfr_tick

// ---- rtl/cfr_relay_chan.sv ----
`timescale 1ns/100ps
module cfr_relay_chan
  import cfr_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             tick,
  // Command
  input  wire logic             apply,
  input  wire logic             cmd_bit,
  input  wire cfr_pkg::cfr_style_e style,
  input  wire logic [DUR_W-1:0] duration,
  // State
  output logic                  relay_on,
  output logic [DUR_W-1:0]      timer
);
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      relay_on <= 1'b0;
      timer    <= '0;
    end
    else if (apply)
    begin
      relay_on <= cmd_bit;
      if (cmd_bit && style == CFR_PULSED)
        timer <= duration;
      else
        timer <= '0;
    end
    else if (tick && timer != '0)
    begin
      timer <= timer - DUR_W'(1);
      if (timer == DUR_W'(1))
        relay_on <= 1'b0;
    end
  end
endmodule : cfr_relay_chan

// ---- verif/cfr_forced_relay_checker.sv ----
`timescale 1ns/100ps
module cfr_forced_relay_checker
  import cfr_pkg::*;
(
  // Clock and reset
  input wire logic                          clk,
  input wire logic                          srst,
  // Avalon-MM slave
  input wire logic [5:0]                    avs_address,
  input wire logic                          avs_read,
  input wire logic                          avs_write,
  input wire logic [31:0]                   avs_readdata,
  input wire logic                          avs_waitrequest,
  input wire logic [1:0]                    avs_response,
  // Relay drives
  input wire logic [cfr_pkg::NUM_RELAYS-1:0] relay_energize
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  wire req  = avs_read | avs_write;
  wire done = req & ~avs_waitrequest;
  wait_first_a: assert property ($rose(req) |-> avs_waitrequest)
    else $error("waitrequest low in first request cycle");
  wait_low_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest high in second request cycle");
  wait_idle_a: assert property (!req |-> !avs_waitrequest)
    else $error("waitrequest high without request");
  relay_rise_a: assert property ((relay_energize & ~$past(relay_energize)) != 4'h0 |->
    $past(avs_write && avs_waitrequest && avs_address == ADDR_COMMAND))
    else $error("relay energized without command write");
  decode_err_a: assert property (done && avs_read && avs_address inside {6'h14, 6'h18, 6'h1c}
    |-> avs_response == 2'h3 && avs_readdata == 32'h0)
    else $error("unmapped read not refused");
  cmd_read_a: assert property (done && avs_read && avs_address == ADDR_COMMAND
    |-> avs_readdata == {28'h0, $past(relay_energize)})
    else $error("command read differs from relays");
  status_read_a: assert property (done && avs_read && avs_address == ADDR_STATUS
    |-> avs_readdata[3:0] == $past(relay_energize) && avs_response == 2'h0)
    else $error("status relay bits differ");
  data_stand_a: assert property (!req |=> $stable(avs_readdata))
    else $error("readdata changed while idle");
  reset_clear_a: assert property ($fell(srst) |-> relay_energize == 4'h0)
    else $error("relays not cleared by reset");
  cover property (done && avs_write && avs_address == ADDR_COMMAND);
  cover property (done && avs_response == 2'h3);
  cover property ($rose(relay_energize[0]));
  cover property ($fell(relay_energize[0]) && !req);
endmodule : cfr_forced_relay_checker

bind cfr_forced_relay cfr_forced_relay_checker cfr_forced_relay_checker_inst (.clk(clk),
  .srst(srst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .avs_response(avs_response), .relay_energize(relay_energize));

// ---- verif/cfr_master.sv ----
`timescale 1ns/100ps
module cfr_master
  import cfr_pkg::*;
(
  // Clock
  input wire logic          clk,
  // Avalon-MM master
  output logic [5:0]        avs_address,
  output logic              avs_read,
  output logic              avs_write,
  output logic [31:0]       avs_writedata,
  output logic [3:0]        avs_byteenable,
  input wire logic [31:0]   avs_readdata,
  input wire logic          avs_waitrequest,
  input wire logic [1:0]    avs_response
);
  initial
  begin
    {avs_address, avs_read, avs_write, avs_writedata, avs_byteenable} <= '0;
  end
  // Request held until the rising edge where waitrequest is seen low
  task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic [1:0] r, output logic ok);
    int n;
    n  = 0;
    ok = 1'b0;
    q  = '0;
    r  = '0;
    avs_address    <= a;
    avs_read       <= !w;
    avs_write      <= w;
    avs_writedata  <= d;
    avs_byteenable <= 4'hf;
    while (!ok && n < 50)
    begin
      @(posedge clk);
      n++;
      if (avs_waitrequest === 1'b0)
      begin
        ok = 1'b1;
        q  = avs_readdata;
        r  = avs_response;
      end
    end
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    // Idle edge so the next call never re-drives in this time step
    @(posedge clk);
  endtask : xfer
endmodule : cfr_master

// ---- verif/comms_forced_relay_outputs_test.sv ----
`timescale 1ns/100ps
module comms_forced_relay_outputs_test;
  import cfr_pkg::*;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [5:0]  avs_address;
  logic        avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0]  avs_byteenable, relay_energize;
  logic [1:0]  avs_response, r;
  int          n_errors = 0;
  int          n_tests = 0;
  logic        ok;
  int          wait_n;
  // Short hold tick so pulses run out within the run
  localparam int BENCH_TICK = 1000;
  always #2 clk = ~clk;
  cfr_forced_relay #(.TICK_LEN(BENCH_TICK)) cfr_forced_relay_inst (.clk(clk), .srst(srst),
    .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .relay_energize(relay_energize));
  cfr_master cfr_master_inst (.clk(clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response));
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
    end
  endtask : chk
  task automatic xf(input logic w, input logic [5:0] a, input logic [31:0] d);
    cfr_master_inst.xfer(w, a, d, q, r, ok);
    if (!ok)
    begin
      n_errors++;
      $display("CHECK FAILED bus_answer expected 1 seen 0");
      stop_test();
    end
  endtask : xf
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    xf(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [5:0] a);
    xf(1'b0, a, 32'h0);
  endtask : rd
  task automatic stop_test();
    $display("errors %0d checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  initial
  begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk("relays_reset", 32'(relay_energize), 32'h0);
    rd(ADDR_DUR_BASE + 6'h4);
    chk("dur_default", q, 32'h5);
    wr(ADDR_COMMAND, 32'hf);
    chk("no_permit", 32'(relay_energize), 32'h0);
    wr(ADDR_PERMIT, 32'h5);
    wr(ADDR_COMMAND, 32'hf);
    chk("masked", 32'(relay_energize), 32'h5);
    wr(ADDR_PERMIT, 32'hf);
    wr(ADDR_COMMAND, 32'ha);
    chk("bits", 32'(relay_energize), 32'ha);
    rd(ADDR_COMMAND);
    chk("cmd_read", q, 32'ha);
    wr(ADDR_OVERRIDE, 32'h40);
    wr(ADDR_COMMAND, 32'h5);
    chk("blocked", 32'(relay_energize), 32'ha);
    rd(ADDR_STATUS);
    chk("status", 32'(q[5:0]), 32'h3a);
    wr(ADDR_OVERRIDE, 32'h0);
    wr(ADDR_STATUS, 32'h20);
    chk("held", 32'(relay_energize), 32'ha);
    wr(ADDR_COMMAND, 32'h0);
    chk("released", 32'(relay_energize), 32'h0);
    wr(ADDR_STYLE, 32'h1);
    wr(ADDR_DUR_BASE, 32'h64);
    wr(ADDR_COMMAND, 32'h9);
    chk("pulse_on", 32'(relay_energize), 32'h9);
    rd(ADDR_TMR_BASE);
    chk("timer", q, 32'h64);
    wr(ADDR_DUR_BASE, 32'hc8);
    wr(ADDR_COMMAND, 32'h9);
    rd(ADDR_TMR_BASE);
    chk("reload", q, 32'hc8);
    wr(ADDR_COMMAND, 32'h0);
    rd(ADDR_TMR_BASE);
    chk("pulse_off", q, 32'h0);
    // Clamping at both ends of the hold range
    wr(ADDR_DUR_BASE + 6'hc, 32'h0);
    rd(ADDR_DUR_BASE + 6'hc);
    chk("dur_lo", q, 32'h5);
    wr(ADDR_DUR_BASE + 6'hc, 32'hffff);
    rd(ADDR_DUR_BASE + 6'hc);
    chk("dur_hi", q, 32'hc350);
    // Shortest pulse runs out on its own, first tick may come early
    wr(ADDR_DUR_BASE, 32'h5);
    wr(ADDR_COMMAND, 32'h1);
    chk("pulse_start", 32'(relay_energize), 32'h1);
    wait_n = 0;
    while (relay_energize[0] !== 1'b0 && wait_n < 8000)
    begin
      @(posedge clk);
      wait_n++;
    end
    chk("pulse_end", 32'(relay_energize), 32'h0);
    chk("pulse_len", 32'(wait_n >= 4 * BENCH_TICK - 4 && wait_n <= 5 * BENCH_TICK),
        32'h1);
    rd(ADDR_TMR_BASE);
    chk("timer_idle", q, 32'h0);
    rd(6'h14);
    chk("unmapped", {r, q[29:0]}, 32'hc0000000);
    stop_test();
  end
endmodule : comms_forced_relay_outputs_test
